/* File: isp_pkg.sv */
package isp_pkg;

	// ==========================================================
	// Register indices; byte address on the bus is index * 4
	localparam logic [7:0] IDX_CONTROL = 8'h9f;
	localparam logic [7:0] IDX_ADDR_LOW = 8'hac;
	localparam logic [7:0] IDX_ADDR_HIGH = 8'had;
	localparam logic [7:0] IDX_DATA = 8'hae;
	localparam logic [7:0] IDX_OPMODE = 8'haf;
	localparam int BUS_ADDR_W = 10;
	localparam int BUS_DATA_W = 32;
	localparam int IDX_LSB = 2;

	// ==========================================================
	// Control register fields
	localparam int CTL_SOFT_RESET = 7;
	localparam int CTL_LOADER_STATUS = 6;
	localparam int CTL_LOADER_SEL = 1;
	localparam int CTL_PROG_EN = 0;

	// ==========================================================
	// Operation mode register fields and codes
	localparam int OPM_BANK = 6;
	localparam int OPM_OUT_ENABLE = 5;
	localparam int OPM_CHIP_ENABLE = 4;
	localparam int OPM_CODE_HI = 3;
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_ERASE = 4'h2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_OPMODE = 8'h30;

	// ==========================================================
	// Region sizes and soft reset timing
	localparam int LOADER_ADDR_BITS = 12;
	localparam int APP_ADDR_BITS = 15;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SOFT_RST_TIME_NS = 32;
	localparam int SOFT_RST_CYCLES =
		(SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum {SEQ_IDLE, SEQ_WAIT, SEQ_DONE} seq_state_t;
	typedef enum {CPU_RUN, CPU_IDLE, CPU_FLASH, CPU_PARK} cpu_state_t;

	// Fold a byte address into the selected region
	function automatic logic [15:0] region_addr(input logic bank,
		input logic [15:0] addr);
		logic [15:0] mask;
		mask = bank ? 16'((1 << LOADER_ADDR_BITS) - 1)
			: 16'((1 << APP_ADDR_BITS) - 1);
		return addr & mask;
	endfunction

endpackage

/* File: isp_if.sv */
`timescale 1ns/1ns
interface isp_reg_if;
	logic [7:0] index;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave(output index, output wr, output wdata, input rdata);
	modport core(input index, input wr, input wdata, output rdata);
endinterface // isp_reg_if

interface isp_op_if;
	logic start;
	logic [3:0] code;
	logic bank;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic done;
	logic busy;
	logic [7:0] rdata;
	modport core(output start, output code, output bank, output addr,
		output wdata, input done, input busy, input rdata);
	modport seq(input start, input code, input bank, input addr,
		input wdata, output done, output busy, output rdata);
endinterface // isp_op_if

/* File: isp_bus_slave.sv */
`timescale 1ns/1ns
module isp_bus_slave
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire logic [isp_pkg::BUS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [isp_pkg::BUS_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [isp_pkg::BUS_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Register side
	isp_reg_if.slave regs
);
	logic ack_q;
	logic [isp_pkg::BUS_DATA_W-1:0] rdata_q;
	wire req = avs_read | avs_write;

	// Fixed one wait state; the write lands on the edge after it, which ends the transfer
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = rdata_q;
	assign regs.index = avs_address[isp_pkg::BUS_ADDR_W-1:isp_pkg::IDX_LSB];
	assign regs.wr = avs_write & ack_q & avs_byteenable[0];
	assign regs.wdata = avs_writedata[7:0];

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			ack_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q)
				rdata_q <= {24'h000000, regs.rdata};
		end
endmodule // isp_bus_slave

/* File: isp_flash_seq.sv */
`timescale 1ns/1ns
module isp_flash_seq
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic soft_clear,
	// Core side
	isp_op_if.seq op,
	// Array side
	output logic [15:0] array_addr,
	output logic [7:0] array_wdata,
	output logic array_bank,
	output logic array_erase,
	output logic array_program,
	output logic array_read,
	input wire logic [7:0] array_rdata,
	input wire logic array_done
);
	isp_pkg::seq_state_t state_q;
	logic is_read_q;
	logic [7:0] rdata_q;
	wire known = op.code == isp_pkg::OP_ERASE ||
		op.code == isp_pkg::OP_PROGRAM || op.code == isp_pkg::OP_READ;
	wire go = state_q == isp_pkg::SEQ_IDLE && op.start;

	assign op.done = state_q == isp_pkg::SEQ_DONE;
	assign op.busy = state_q != isp_pkg::SEQ_IDLE;
	assign op.rdata = rdata_q;

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			state_q <= isp_pkg::SEQ_IDLE;
			{array_erase, array_program, array_read, is_read_q} <= 4'h0;
			array_addr <= 16'h0000;
			array_wdata <= 8'h00;
			array_bank <= 1'b0;
			rdata_q <= 8'h00;
		end
		else if (soft_clear)
		begin
			state_q <= isp_pkg::SEQ_IDLE;
			{array_erase, array_program, array_read, is_read_q} <= 4'h0;
		end
		else
		begin
			// Strobes last one cycle, issued on the start edge
			array_erase <= go && op.code == isp_pkg::OP_ERASE;
			array_program <= go && op.code == isp_pkg::OP_PROGRAM;
			array_read <= go && op.code == isp_pkg::OP_READ;
			case (state_q)
				isp_pkg::SEQ_IDLE:
					if (op.start)
					begin
						array_bank <= op.bank;
						// Whole-region erase takes no address or data
						array_addr <= op.code == isp_pkg::OP_ERASE ? 16'h0000
							: isp_pkg::region_addr(op.bank, op.addr);
						array_wdata <= op.wdata;
						is_read_q <= op.code == isp_pkg::OP_READ;
						state_q <= known ? isp_pkg::SEQ_WAIT : isp_pkg::SEQ_DONE;
					end
				isp_pkg::SEQ_WAIT:
					if (array_done)
					begin
						if (is_read_q)
							rdata_q <= array_rdata;
						state_q <= isp_pkg::SEQ_DONE;
					end
				isp_pkg::SEQ_DONE:
					state_q <= isp_pkg::SEQ_IDLE;
				default:
					state_q <= isp_pkg::SEQ_IDLE;
			endcase
		end
endmodule // isp_flash_seq

/* File: in_system_flash_programming_control.sv */
// Function
// - Writing soft reset bit resets device like the reset pin; bit self-clears.
// - Soft reset bit reads one while the reboot is being invoked.
// - Loader status bit is read-only: one when running from loader region.
// - Loader fetch select routes code fetch to the loader region.
// - Programming enable enters mode driven by opmode, address, data.
// - Idle request in programming mode starts the flash operation instead.
// - Clearing programming enable restores genuine idle on idle request.
// - Control 0x83, timer, idle: timeout resets, restart from application.
// - High and low address registers form the 16-bit byte address.
// - Every flash byte read or written passes the data buffer.
// - Bank select: zero application region, one loader region.
// - Opmode output enable bit drives array output enable.
// - Opmode chip enable bit drives array chip enable.
// - Code 0010 erase region, 0001 program byte, 0000 read byte.
// - Loader region 4KB, application 32KB, handled independently.
`timescale 1ns/1ns
module in_system_flash_programming_control
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Avalon-MM register slave
	input wire logic [isp_pkg::BUS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [isp_pkg::BUS_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [isp_pkg::BUS_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// External reset pin, active high, asynchronous to clk_sys
	input wire logic reset_pin,
	// CPU handshake
	input wire logic idle_request_bit,
	input wire logic cpu_wake,
	output logic cpu_idle,
	output logic cpu_flash_hold,
	output logic device_reset,
	output logic fetch_from_loader,
	// Flash arrays
	output logic [15:0] array_addr,
	output logic [7:0] array_wdata,
	output logic array_bank,
	output logic array_erase,
	output logic array_program,
	output logic array_read,
	output logic array_output_enable_ctl,
	output logic array_chip_enable_ctl,
	input wire logic [7:0] array_rdata,
	input wire logic array_done
);

	// ==========================================================
	// Internal carriers
	isp_reg_if regs();
	isp_op_if op();

	// ==========================================================
	// Reset pin synchroniser
	logic pin_meta_q;
	logic pin_sync_q;

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= reset_pin;
			pin_sync_q <= pin_meta_q;
		end

	// ==========================================================
	// Whole-device reset
	// A soft reset runs the same stretch as a pin reset, so the rest
	// of the chip cannot tell the two apart.
	localparam logic [7:0] RST_COUNT =
		8'(isp_pkg::SOFT_RST_CYCLES);
	logic [7:0] rst_cnt_q;
	logic [7:0] rst_cnt_d;
	logic fire_soft;
	wire soft_active = rst_cnt_q != 8'h00;
	wire dev_clear = pin_sync_q | soft_active;

	assign rst_cnt_d = pin_sync_q ? RST_COUNT
		: fire_soft ? RST_COUNT
		: soft_active ? rst_cnt_q - 8'h01 : 8'h00;

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			rst_cnt_q <= 8'h00;
		else
			rst_cnt_q <= rst_cnt_d;

	assign device_reset = dev_clear;

	// ==========================================================
	// Register decode
	wire wr_ctl = regs.wr && regs.index == isp_pkg::IDX_CONTROL;
	wire wr_al = regs.wr && regs.index == isp_pkg::IDX_ADDR_LOW;
	wire wr_ah = regs.wr && regs.index == isp_pkg::IDX_ADDR_HIGH;
	wire wr_fd = regs.wr && regs.index == isp_pkg::IDX_DATA;
	wire wr_om = regs.wr && regs.index == isp_pkg::IDX_OPMODE;
	wire wd_reboot = regs.wdata[isp_pkg::CTL_SOFT_RESET];
	wire wd_loader_sel = regs.wdata[isp_pkg::CTL_LOADER_SEL];
	wire wd_prog_en = regs.wdata[isp_pkg::CTL_PROG_EN];

	// ==========================================================
	// Software registers
	logic reboot_q;
	logic loader_sel_q;
	logic prog_en_q;
	logic read_op_q;
	logic exec_loader_q;
	logic [7:0] addr_low_q;
	logic [7:0] addr_high_q;
	logic [7:0] data_q;
	logic [7:0] opmode_q;

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			reboot_q <= 1'b0;
			loader_sel_q <= 1'b0;
			prog_en_q <= 1'b0;
			exec_loader_q <= 1'b0;
		end
		else if (dev_clear)
		begin
			// Restart always from the application region
			reboot_q <= 1'b0;
			loader_sel_q <= 1'b0;
			prog_en_q <= 1'b0;
			exec_loader_q <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
			begin
				reboot_q <= wd_reboot;
				loader_sel_q <= wd_loader_sel;
				prog_en_q <= wd_prog_en;
			end
			exec_loader_q <= loader_sel_q;
		end

	// Op code latched at start, so a mode rewrite in mid-operation
	// cannot turn a program into a read-back
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			read_op_q <= 1'b0;
		else if (dev_clear)
			read_op_q <= 1'b0;
		else if (op.start)
			read_op_q <= op.code == isp_pkg::OP_READ;

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			addr_low_q <= isp_pkg::RST_BYTE;
			addr_high_q <= isp_pkg::RST_BYTE;
			data_q <= isp_pkg::RST_BYTE;
			opmode_q <= isp_pkg::RST_OPMODE;
		end
		else if (dev_clear)
		begin
			addr_low_q <= isp_pkg::RST_BYTE;
			addr_high_q <= isp_pkg::RST_BYTE;
			data_q <= isp_pkg::RST_BYTE;
			opmode_q <= isp_pkg::RST_OPMODE;
		end
		else
		begin
			if (wr_al)
				addr_low_q <= regs.wdata;
			if (wr_ah)
				addr_high_q <= regs.wdata;
			if (wr_om)
				opmode_q <= regs.wdata;
			// Array read data wins over a software write in the same cycle
			if (op.done && read_op_q)
				data_q <= op.rdata;
			else if (wr_fd)
				data_q <= regs.wdata;
		end

	// ==========================================================
	// Read back; unmapped indices read as zero
	wire [7:0] ctl_view = {reboot_q, exec_loader_q, 4'h0, loader_sel_q,
		prog_en_q};

	assign regs.rdata =
		regs.index == isp_pkg::IDX_CONTROL ? ctl_view
		: regs.index == isp_pkg::IDX_ADDR_LOW ? addr_low_q
		: regs.index == isp_pkg::IDX_ADDR_HIGH ? addr_high_q
		: regs.index == isp_pkg::IDX_DATA ? data_q
		: regs.index == isp_pkg::IDX_OPMODE ? opmode_q
		: 8'h00;

	// ==========================================================
	// Operation request to the sequencer
	assign op.code = opmode_q[isp_pkg::OPM_CODE_HI:0];
	assign op.bank = opmode_q[isp_pkg::OPM_BANK];
	assign op.addr = {addr_high_q, addr_low_q};
	assign op.wdata = data_q;

	// ==========================================================
	// CPU idle handling
	// With a reboot pending and programming enabled, idle parks the CPU until the timer wakes it;
	// the wake then fires the reset instead of resuming code.
	isp_pkg::cpu_state_t cpu_q;
	isp_pkg::cpu_state_t cpu_d;
	logic start_d;

	always_comb
	begin
		cpu_d = cpu_q;
		start_d = 1'b0;
		fire_soft = 1'b0;
		case (cpu_q)
			isp_pkg::CPU_RUN:
				if (reboot_q && !prog_en_q)
					fire_soft = 1'b1;
				else if (idle_request_bit && reboot_q)
					cpu_d = isp_pkg::CPU_PARK;
				else if (idle_request_bit && prog_en_q)
				begin
					start_d = 1'b1;
					cpu_d = isp_pkg::CPU_FLASH;
				end
				else if (idle_request_bit)
					cpu_d = isp_pkg::CPU_IDLE;
			isp_pkg::CPU_IDLE:
				if (cpu_wake)
					cpu_d = isp_pkg::CPU_RUN;
			isp_pkg::CPU_FLASH:
				if (op.done)
					cpu_d = isp_pkg::CPU_RUN;
			isp_pkg::CPU_PARK:
				if (cpu_wake)
				begin
					fire_soft = 1'b1;
					cpu_d = isp_pkg::CPU_RUN;
				end
			default:
				cpu_d = isp_pkg::CPU_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			cpu_q <= isp_pkg::CPU_RUN;
		else if (dev_clear)
			cpu_q <= isp_pkg::CPU_RUN;
		else
			cpu_q <= cpu_d;

	// Busy and device-reset guards; a running CPU already implies an idle sequencer
	assign op.start = start_d & ~dev_clear & ~op.busy;
	assign cpu_idle = cpu_q == isp_pkg::CPU_IDLE ||
		cpu_q == isp_pkg::CPU_PARK;
	assign cpu_flash_hold = cpu_q == isp_pkg::CPU_FLASH;
	assign fetch_from_loader = loader_sel_q;

	// ==========================================================
	// Array strobes and enables
	assign array_output_enable_ctl =
		opmode_q[isp_pkg::OPM_OUT_ENABLE];
	assign array_chip_enable_ctl =
		opmode_q[isp_pkg::OPM_CHIP_ENABLE];

	isp_bus_slave u_bus
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.regs(regs.slave)
	);

	// Region masking and op-code dispatch live in the sequencer
	isp_flash_seq u_seq
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.soft_clear(dev_clear),
		.op(op.seq),
		.array_addr(array_addr),
		.array_wdata(array_wdata),
		.array_bank(array_bank),
		.array_erase(array_erase),
		.array_program(array_program),
		.array_read(array_read),
		.array_rdata(array_rdata),
		.array_done(array_done)
	);

endmodule // in_system_flash_programming_control

/* File: in_system_flash_programming_control_asserts.sv */
`timescale 1ns/1ns
module isp_ctl_asserts
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// CPU side
	input wire logic reset_pin,
	input wire logic cpu_idle,
	input wire logic cpu_flash_hold,
	input wire logic device_reset,
	input wire logic fetch_from_loader,
	// Array side
	input wire logic [15:0] array_addr,
	input wire logic array_bank,
	input wire logic array_erase,
	input wire logic array_program,
	input wire logic array_read,
	input wire logic array_done
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	wire any_strobe;
	wire byte_op;
	assign any_strobe = array_erase | array_program | array_read;
	assign byte_op = array_program | array_read;
	// ==========================================================
	// Flash operation
	sequence done_seen;
		cpu_flash_hold && array_done;
	endsequence
	sequence hold_then_drop;
		cpu_flash_hold ##1 !cpu_flash_hold;
	endsequence
	strobe_in_hold_a:
		assert property (any_strobe |-> cpu_flash_hold)
		else $error("array strobe outside flash hold");
	idle_excl_a:
		assert property (!(cpu_idle && cpu_flash_hold))
		else $error("idle and flash hold together");
	strobe_single_a:
		assert property (any_strobe |->
			$onehot({array_erase, array_program, array_read}) ##1 !any_strobe)
		else $error("strobe not single or longer than one cycle");
	erase_addr_a:
		assert property (array_erase |-> array_addr == 16'h0000)
		else $error("erase with nonzero address");
	bank_mask_a:
		assert property (byte_op |-> (array_bank ?
			array_addr[15:12] == 4'h0 : !array_addr[15]))
		else $error("address outside selected region");
	done_release_a:
		assert property (done_seen |=> hold_then_drop)
		else $error("hold not released after array done");
	app_restart_a:
		assert property ($fell(device_reset) |-> !fetch_from_loader)
		else $error("restart not from application region");
	pin_reset_a:
		assert property ($rose(reset_pin) |-> ##[1:4] device_reset)
		else $error("reset pin did not reset device");
endmodule // isp_ctl_asserts

bind in_system_flash_programming_control isp_ctl_asserts chk_u (.clk_sys,
	.reset_n, .reset_pin, .cpu_idle, .cpu_flash_hold, .device_reset,
	.fetch_from_loader, .array_addr, .array_bank, .array_erase,
	.array_program, .array_read, .array_done);

/* File: flash_array_model.sv */
`timescale 1ns/1ns
module flash_array_model
(
	// Clock
	input wire logic clk_sys,
	// Array control
	input wire logic [15:0] array_addr,
	input wire logic [7:0] array_wdata,
	input wire logic array_bank,
	input wire logic array_erase,
	input wire logic array_program,
	input wire logic array_read,
	input wire logic [3:0] latency,
	// Answer
	output logic [7:0] array_rdata = 8'h00,
	output logic array_done = 1'b0
);
	logic [7:0] loader_mem [int];
	logic [7:0] app_mem [int];
	logic [3:0] cnt_q = 4'h0;
	logic [2:0] op_q = 3'b000;
	// ==========================================================
	// Unwritten bytes read as erased
	function automatic logic [7:0] rd(input logic b, input int a);
		if (b)
			return loader_mem.exists(a) ? loader_mem[a] : 8'hff;
		return app_mem.exists(a) ? app_mem[a] : 8'hff;
	endfunction
	// ==========================================================
	// Operation; read data toggles every cycle except the done cycle of a read
	always @(posedge clk_sys)
	begin
		array_done <= 1'b0;
		array_rdata <= ~array_rdata;
		if (array_erase | array_program | array_read)
		begin
			op_q <= {array_erase, array_program, array_read};
			cnt_q <= latency;
		end
		else if (cnt_q != 4'h0)
		begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1)
				array_done <= 1'b1;
			if (cnt_q == 4'h1 && op_q[2] && array_bank)
				loader_mem.delete();
			if (cnt_q == 4'h1 && op_q[2] && !array_bank)
				app_mem.delete();
			if (cnt_q == 4'h1 && op_q[1] && array_bank)
				loader_mem[int'(array_addr)] = array_wdata;
			if (cnt_q == 4'h1 && op_q[1] && !array_bank)
				app_mem[int'(array_addr)] = array_wdata;
			if (cnt_q == 4'h1 && op_q[0])
				array_rdata <= rd(array_bank, int'(array_addr));
		end
	end
endmodule // flash_array_model

/* File: in_system_flash_programming_control_bench.sv */
`timescale 1ns/1ns
module in_system_flash_programming_control_bench;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [isp_pkg::BUS_ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hf;
	logic reset_pin = 1'b0;
	logic idle_request_bit = 1'b0;
	logic cpu_wake = 1'b0;
	logic [3:0] latency = 4'h1;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, cpu_idle, cpu_flash_hold, device_reset;
	wire fetch_from_loader, array_bank, array_erase, array_program;
	wire array_read, array_output_enable_ctl, array_chip_enable_ctl;
	wire array_done;
	wire [15:0] array_addr;
	wire [7:0] array_wdata, array_rdata;
	int errors = 0;
	int comparisons = 0;
	always #4 clk_sys = ~clk_sys;
	in_system_flash_programming_control dut_u (.clk_sys, .reset_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .reset_pin,
		.idle_request_bit, .cpu_wake, .cpu_idle, .cpu_flash_hold,
		.device_reset, .fetch_from_loader, .array_addr, .array_wdata,
		.array_bank, .array_erase, .array_program, .array_read,
		.array_output_enable_ctl, .array_chip_enable_ctl, .array_rdata,
		.array_done);
	flash_array_model array_u (.clk_sys, .array_addr, .array_wdata,
		.array_bank, .array_erase, .array_program, .array_read, .latency,
		.array_rdata, .array_done);
	// ==========================================================
	// Shared tasks
	task summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= {i, 2'b00};
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= !w;
		@(negedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			n++;
			@(negedge clk_sys);
		end
		chk("bus answer", 8'h00, avs_waitrequest);
		r = avs_readdata[7:0];
		@(posedge clk_sys);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(negedge clk_sys);
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] v;
		bus(1'b1, i, d, v);
	endtask
	task rdc(input string s, input logic [7:0] i, input logic [7:0] e);
		logic [7:0] v;
		bus(1'b0, i, 8'h00, v);
		chk(s, e, v);
	endtask
	task pulse(input logic wake);
		@(posedge clk_sys);
		idle_request_bit <= !wake;
		cpu_wake <= wake;
		@(posedge clk_sys);
		idle_request_bit <= 1'b0;
		cpu_wake <= 1'b0;
		@(negedge clk_sys);
	endtask
	task wait_rst(input logic lvl);
		int n;
		n = 0;
		while (device_reset !== lvl && n < 40)
		begin
			n++;
			@(negedge clk_sys);
		end
		chk("device reset", lvl, device_reset);
	endtask
	task run_op(input logic [3:0] c, input logic b, input logic [15:0] a,
		input logic [7:0] d);
		int n;
		logic [15:0] ea;
		n = 0;
		ea = a & (b ? 16'h0fff : 16'h7fff);
		if (c == isp_pkg::OP_ERASE)
			ea = 16'h0000;
		wr(isp_pkg::IDX_ADDR_HIGH, a[15:8]);
		wr(isp_pkg::IDX_ADDR_LOW, a[7:0]);
		wr(isp_pkg::IDX_DATA, d);
		wr(isp_pkg::IDX_OPMODE, {1'b0, b, 2'b11, c});
		wr(isp_pkg::IDX_CONTROL, 8'h01);
		pulse(1'b0);
		chk("hold", 8'h01, cpu_flash_hold);
		chk("idle", 8'h00, cpu_idle);
		chk("addr high", ea[15:8], array_addr[15:8]);
		chk("addr low", ea[7:0], array_addr[7:0]);
		chk("bank", b, array_bank);
		chk("strobe", {c == isp_pkg::OP_ERASE, c == isp_pkg::OP_PROGRAM,
			c == isp_pkg::OP_READ}, {array_erase, array_program,
			array_read});
		if (c == isp_pkg::OP_PROGRAM)
			chk("array data", d, array_wdata);
		while (cpu_flash_hold !== 1'b0 && n < 40)
		begin
			n++;
			@(negedge clk_sys);
		end
		chk("hold release", 8'h00, cpu_flash_hold);
	endtask
	// ==========================================================
	// Scenarios
	task t_regs;
		rdc("control", isp_pkg::IDX_CONTROL, 8'h00);
		rdc("opmode", isp_pkg::IDX_OPMODE, 8'h30);
		rdc("unmapped", 8'ha0, 8'h00);
		@(posedge clk_sys);
		avs_byteenable <= 4'he;
		wr(isp_pkg::IDX_ADDR_LOW, 8'h55);
		@(posedge clk_sys);
		avs_byteenable <= 4'hf;
		rdc("lane off", isp_pkg::IDX_ADDR_LOW, 8'h00);
		wr(isp_pkg::IDX_OPMODE, 8'h20);
		chk("oe", 8'h01, array_output_enable_ctl);
		chk("ce", 8'h00, array_chip_enable_ctl);
		wr(isp_pkg::IDX_CONTROL, 8'h40);
		rdc("status ro", isp_pkg::IDX_CONTROL, 8'h00);
		wr(isp_pkg::IDX_CONTROL, 8'h02);
		chk("fetch", 8'h01, fetch_from_loader);
		rdc("status", isp_pkg::IDX_CONTROL, 8'h42);
		wr(isp_pkg::IDX_CONTROL, 8'h00);
	endtask
	task t_ops;
		run_op(isp_pkg::OP_PROGRAM, 1'b0, 16'hf234, 8'ha5);
		latency <= 4'h9;
		run_op(isp_pkg::OP_PROGRAM, 1'b1, 16'hf234, 8'h5a);
		run_op(isp_pkg::OP_READ, 1'b0, 16'h7234, 8'h00);
		rdc("read app", isp_pkg::IDX_DATA, 8'ha5);
		latency <= 4'h1;
		run_op(isp_pkg::OP_READ, 1'b1, 16'h0234, 8'h00);
		rdc("read loader", isp_pkg::IDX_DATA, 8'h5a);
		run_op(isp_pkg::OP_ERASE, 1'b1, 16'h1111, 8'h77);
		run_op(isp_pkg::OP_READ, 1'b1, 16'h0234, 8'h00);
		rdc("erased", isp_pkg::IDX_DATA, 8'hff);
		run_op(isp_pkg::OP_READ, 1'b0, 16'h7234, 8'h00);
		rdc("kept", isp_pkg::IDX_DATA, 8'ha5);
		run_op(4'h5, 1'b0, 16'h1234, 8'h33);
		rdc("no op data", isp_pkg::IDX_DATA, 8'h33);
	endtask
	task t_idle;
		wr(isp_pkg::IDX_CONTROL, 8'h00);
		pulse(1'b0);
		chk("true idle", 8'h01, cpu_idle);
		chk("no hold", 8'h00, cpu_flash_hold);
		pulse(1'b1);
		@(negedge clk_sys);
		chk("woken", 8'h00, cpu_idle);
		chk("no reset", 8'h00, device_reset);
	endtask
	task t_soft;
		wr(isp_pkg::IDX_ADDR_LOW, 8'h3c);
		wr(isp_pkg::IDX_CONTROL, 8'h83);
		rdc("reboot", isp_pkg::IDX_CONTROL, 8'hc3);
		pulse(1'b0);
		chk("parked", 8'h01, cpu_idle);
		chk("early reset", 8'h00, device_reset);
		pulse(1'b1);
		wait_rst(1'b1);
		wait_rst(1'b0);
		chk("app fetch", 8'h00, fetch_from_loader);
		rdc("ctl cleared", isp_pkg::IDX_CONTROL, 8'h00);
		rdc("addr cleared", isp_pkg::IDX_ADDR_LOW, 8'h00);
	endtask
	task t_pin;
		wr(isp_pkg::IDX_ADDR_LOW, 8'h3c);
		@(posedge clk_sys);
		reset_pin <= 1'b1;
		wait_rst(1'b1);
		@(posedge clk_sys);
		reset_pin <= 1'b0;
		wait_rst(1'b0);
		rdc("pin cleared", isp_pkg::IDX_ADDR_LOW, 8'h00);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_regs;
		t_ops;
		t_idle;
		t_soft;
		t_pin;
		summarize;
	end
	initial
	begin
		#100000;
		errors++;
		summarize;
	end
endmodule // in_system_flash_programming_control_bench
